/* File: fcs_params.svh */
// timing, command, field and offset constants of the flash command controller
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_CLK_PERIOD_NS  50
`define FCS_T_WE_PULSE_NS  70
`define FCS_T_ACCESS_NS    70
`define FCS_WE_CYC   ((`FCS_T_WE_PULSE_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_ACC_CYC  ((`FCS_T_ACCESS_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_SYNC_CYC 2
`define FCS_DQ_W     16
`define FCS_CMD_READ_ARRAY  16'h00FF
`define FCS_CMD_READ_ID     16'h0090
`define FCS_CMD_QUERY       16'h0098
`define FCS_CMD_READ_STATUS 16'h0070
`define FCS_CMD_CLEAR       16'h0050
`define FCS_CMD_PROG_SETUP  16'h0040
`define FCS_CMD_PROG_ALT    16'h0010
`define FCS_CMD_ERASE_SETUP 16'h0020
`define FCS_CMD_CONFIRM     16'h00D0
`define FCS_CMD_SUSPEND     16'h00B0
`define FCS_CMD_LOCK_SETUP  16'h0060
`define FCS_CMD_LOCK_BLOCK  16'h0001
`define FCS_CMD_LOCKDOWN    16'h002F
`define FCS_CMD_PROT_SETUP  16'h00C0
`define FCS_CMD_PROT_LOCK   16'hFFFD
`define FCS_SR_READY        7
`define FCS_SR_ERASE_FAIL   5
`define FCS_SR_PROG_FAIL    4
`define FCS_SR_VPP_LOW      3
`define FCS_SR_LOCKED       1
`define FCS_SR_RSVD         0
`define FCS_REG_CTRL        8'h00
`define FCS_REG_ADDR        8'h04
`define FCS_REG_DATA        8'h08
`define FCS_REG_RDATA       8'h0C
`define FCS_REG_STATUS      8'h10
`define FCS_REG_CFG         8'h14
`define FCS_REG_IRQ_STAT    8'h18
`define FCS_REG_IRQ_MASK    8'h1C
`define FCS_IRQ_DONE        0
`define FCS_IRQ_ERR         1
`define FCS_IRQ_SEQ         2
`endif

/* File: fcs_pkg.sv */
// types of the flash command controller
package fcs_pkg;
    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0, OP_READ_ID = 4'h1, OP_QUERY = 4'h2, OP_READ_STATUS = 4'h3,
        OP_CLEAR = 4'h4, OP_PROGRAM = 4'h5, OP_PROGRAM_ALT = 4'h6, OP_ERASE = 4'h7,
        OP_SUSPEND = 4'h8, OP_RESUME = 4'h9, OP_LOCK = 4'hA, OP_UNLOCK = 4'hB,
        OP_LOCKDOWN = 4'hC, OP_PROT_PROG = 4'hD, OP_PROT_LOCK = 4'hE
    } fcs_op_t;
    typedef enum logic [1:0] {SEC_NONE = 2'h0, SEC_WRITE = 2'h1, SEC_READ = 2'h2} fcs_sec_t;
    typedef struct packed {
        logic [15:0] code1;
        fcs_sec_t    second;
        logic [15:0] code2;
        logic        use_data;
        logic        poll;
    } fcs_plan_t;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_W1 = 7'h02, S_W2 = 7'h04, S_RD = 7'h08,
        S_W70 = 7'h10, S_POLL = 7'h20, S_END = 7'h40
    } fcs_fsm_t;
    typedef enum logic [3:0] {
        C_IDLE = 4'h1, C_SETUP = 4'h2, C_PULSE = 4'h4, C_HOLD = 4'h8
    } fcs_cyc_st_t;
endpackage

/* File: fcs_cyc_if.sv */
// one flash bus cycle request between sequencer and pin driver
`timescale 1ns/1ps
`default_nettype none
interface fcs_cyc_if #(parameter int AW = 20);
    logic          req;
    logic          wr;
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic [15:0]   rdata;
    logic          done;
    modport eng (output req, wr, addr, wdata, input rdata, done);
    modport phy (input req, wr, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

/* File: fcs_sync2.sv */
// two-flop synchroniser for the flash data pins
`timescale 1ns/1ps
`default_nettype none
module fcs_sync2 #(
    parameter int W = 16
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t st;
    sync_t next_st;
    always_comb begin
        next_st.s1 = i_d;
        next_st.s2 = st.s1;
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign o_q = st.s2;
endmodule
`default_nettype wire

/* File: fcs_bus_cycle.sv */
// drives one asynchronous flash write or read cycle on the pins
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
module fcs_bus_cycle import fcs_pkg::*; #(
    parameter int AW = 20
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_arst_n,
    fcs_cyc_if.phy             cyc,
    input  wire logic [15:0]   i_dq_sync,
    output logic               o_ce_n,
    output logic               o_oe_n,
    output logic               o_we_n,
    output logic      [AW-1:0] o_addr,
    output logic      [15:0]   o_dq,
    output logic               o_dq_oe
);
    typedef struct packed {
        fcs_cyc_st_t   cst;
        logic [3:0]    cnt;
        logic          wr;
        logic          ce_n;
        logic          oe_n;
        logic          we_n;
        logic          dq_oe;
        logic [AW-1:0] addr;
        logic [15:0]   dq;
        logic [15:0]   rdata;
        logic          done;
    } cyc_t;
    cyc_t st;
    cyc_t next_st;
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.cst)
            C_IDLE: begin
                // done guard: the sequencer drops req one cycle after done
                if (cyc.req && !st.done) begin
                    next_st.wr    = cyc.wr;
                    next_st.addr  = cyc.addr;
                    next_st.dq    = cyc.wdata;
                    next_st.ce_n  = 1'b0;
                    next_st.oe_n  = cyc.wr;
                    next_st.dq_oe = !cyc.wr;
                    next_st.cst   = C_SETUP;
                end
            end
            C_SETUP: begin
                next_st.we_n = !st.wr;
                next_st.cnt  = st.wr ? 4'(`FCS_WE_CYC - 1)
                                     : 4'(`FCS_ACC_CYC + `FCS_SYNC_CYC - 1);
                next_st.cst  = C_PULSE;
            end
            C_PULSE: begin
                if (st.cnt == 4'h0) begin
                    next_st.we_n = 1'b1;
                    next_st.oe_n = 1'b1;
                    if (!st.wr) begin
                        next_st.rdata = i_dq_sync;
                    end
                    next_st.cst = C_HOLD;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            C_HOLD: begin
                // data held past the rising write strobe, then released
                next_st.ce_n  = 1'b1;
                next_st.dq_oe = 1'b1;
                next_st.done  = 1'b1;
                next_st.cst   = C_IDLE;
            end
            default: begin
                next_st = st;
                next_st.cst = C_IDLE;
            end
        endcase
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st       <= '0;
            st.cst   <= C_IDLE;
            st.ce_n  <= 1'b1;
            st.oe_n  <= 1'b1;
            st.we_n  <= 1'b1;
            st.dq_oe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    assign o_ce_n    = st.ce_n;
    assign o_oe_n    = st.oe_n;
    assign o_we_n    = st.we_n;
    assign o_addr    = st.addr;
    assign o_dq      = st.dq;
    assign o_dq_oe   = st.dq_oe;
    assign cyc.rdata = st.rdata;
    assign cyc.done  = st.done;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    we_pulse_a: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
        else $error("write strobe not two cycles");
    oe_release_a: assert property ($fell(o_oe_n) |-> ##[1:8] $rose(o_oe_n) ##1 o_ce_n)
        else $error("output enable not released after read");
endmodule
`default_nettype wire

/* File: fcs_flash_ctrl.sv */
// apb-controlled host sequencer for a parallel nor flash command interface
//
// Contract
// - erase is 20h then D0h at block; lock setup 60h then 01h, D0h or 2Fh
// - FFh, 50h, B0h, D0h are single writes; after 70h reads give status
// - program setup is 40h (or 10h), then location and word
// - protection program is C0h then data; its lock writes FFFD
// - write-protect stays steady through unlock and one cycle beyond
// - ready bit 7 is tested before error bits are believed
// - reserved bit 0 is masked out of every poll
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
module fcs_flash_ctrl import fcs_pkg::*; #(
    parameter int AW = 20
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_psel,
    input  wire logic          i_penable,
    input  wire logic          i_pwrite,
    input  wire logic [7:0]    i_paddr,
    input  wire logic [31:0]   i_pwdata,
    output logic      [31:0]   o_prdata,
    output logic               o_pready,
    output logic               o_pslverr,
    output logic               o_flash_ce_n,
    output logic               o_flash_oe_n,
    output logic               o_flash_we_n,
    output logic      [AW-1:0] o_flash_addr,
    output logic      [15:0]   o_flash_dq,
    output logic               o_flash_dq_oe,
    input  wire logic [15:0]   i_flash_dq,
    output logic               o_flash_wp_n,
    output logic               o_irq
);
    typedef struct packed {
        fcs_fsm_t      fsm;
        fcs_op_t       op;
        logic [AW-1:0] addr;
        logic [15:0]   wdata;
        logic [15:0]   rdata;
        logic [7:0]    sr;
        logic          wp_req;
        logic          wp_n;
        logic [2:0]    irq_stat;
        logic [2:0]    irq_mask;
        logic          req;
        logic          wr;
        logic [AW-1:0] caddr;
        logic [15:0]   cdata;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic          irq;
    } ctl_t;

    ctl_t        st;
    ctl_t        next_st;
    fcs_plan_t   plan;
    logic [15:0] dq_sync;
    logic [7:0]  sr_in;
    logic        acc;
    logic        wr_ok;
    logic        busy;
    logic        mapped;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;
    logic [31:0] rd_mux;

    fcs_cyc_if #(.AW(AW)) cyc ();

    fcs_sync2 #(.W(`FCS_DQ_W)) u_sync (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_d        (i_flash_dq),
        .o_q        (dq_sync)
    );

    fcs_bus_cycle #(.AW(AW)) u_cycle (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .cyc        (cyc.phy),
        .i_dq_sync  (dq_sync),
        .o_ce_n     (o_flash_ce_n),
        .o_oe_n     (o_flash_oe_n),
        .o_we_n     (o_flash_we_n),
        .o_addr     (o_flash_addr),
        .o_dq       (o_flash_dq),
        .o_dq_oe    (o_flash_dq_oe)
    );

    // command codes and shape of each operation
    function automatic fcs_plan_t plan_of(input fcs_op_t op);
        fcs_plan_t p;
        p = '0;
        p.code1 = `FCS_CMD_READ_ARRAY;
        case (op)
            OP_READ_ARRAY: p.code1 = `FCS_CMD_READ_ARRAY;
            OP_READ_ID: begin
                p.code1  = `FCS_CMD_READ_ID;
                p.second = SEC_READ;
            end
            OP_QUERY: begin
                p.code1  = `FCS_CMD_QUERY;
                p.second = SEC_READ;
            end
            OP_READ_STATUS: begin
                p.code1  = `FCS_CMD_READ_STATUS;
                p.second = SEC_READ;
            end
            OP_CLEAR:   p.code1 = `FCS_CMD_CLEAR;
            // suspend polls until halted and ready
            OP_SUSPEND: begin
                p.code1 = `FCS_CMD_SUSPEND;
                p.poll  = 1'b1;
            end
            OP_RESUME: p.code1 = `FCS_CMD_CONFIRM;
            OP_PROGRAM, OP_PROGRAM_ALT: begin
                p.code1    = (op == OP_PROGRAM) ? `FCS_CMD_PROG_SETUP : `FCS_CMD_PROG_ALT;
                p.second   = SEC_WRITE;
                p.use_data = 1'b1;
                p.poll     = 1'b1;
            end
            OP_ERASE: begin
                p.code1  = `FCS_CMD_ERASE_SETUP;
                p.code2  = `FCS_CMD_CONFIRM;
                p.second = SEC_WRITE;
                p.poll   = 1'b1;
            end
            OP_LOCK, OP_UNLOCK, OP_LOCKDOWN: begin
                p.code1  = `FCS_CMD_LOCK_SETUP;
                p.code2  = (op == OP_LOCK)   ? `FCS_CMD_LOCK_BLOCK :
                           (op == OP_UNLOCK) ? `FCS_CMD_CONFIRM : `FCS_CMD_LOCKDOWN;
                p.second = SEC_WRITE;
                p.poll   = 1'b1;
            end
            OP_PROT_PROG, OP_PROT_LOCK: begin
                p.code1    = `FCS_CMD_PROT_SETUP;
                p.code2    = `FCS_CMD_PROT_LOCK;
                p.use_data = (op == OP_PROT_PROG);
                p.second   = SEC_WRITE;
                p.poll     = 1'b1;
            end
            default: p.code1 = `FCS_CMD_READ_ARRAY;
        endcase
        return p;
    endfunction

    always_comb begin
        plan   = plan_of(st.op);
        acc    = i_psel && i_penable;
        wr_ok  = acc && st.pready && i_pwrite;
        busy   = (st.fsm != S_IDLE);
        sr_in  = cyc.rdata[7:0] & ~(8'h01 << `FCS_SR_RSVD);
        mapped = (i_paddr[7:5] == 3'h0) && (i_paddr[1:0] == 2'h0);
        case (i_paddr)
            `FCS_REG_CTRL:     rd_mux = {28'h0000000, st.op};
            `FCS_REG_ADDR:     rd_mux = 32'(st.addr);
            `FCS_REG_DATA:     rd_mux = {16'h0000, st.wdata};
            `FCS_REG_RDATA:    rd_mux = {16'h0000, st.rdata};
            `FCS_REG_STATUS:   rd_mux = {16'h0000, st.sr, 5'h00, st.wp_n, st.wp_req, busy};
            `FCS_REG_CFG:      rd_mux = {31'h00000000, st.wp_req};
            `FCS_REG_IRQ_STAT: rd_mux = {29'h00000000, st.irq_stat};
            `FCS_REG_IRQ_MASK: rd_mux = {29'h00000000, st.irq_mask};
            default:           rd_mux = 32'h00000000;
        endcase
    end

    always_comb begin
        next_st         = st;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        irq_set         = 3'h0;
        irq_clr         = 3'h0;
        // one wait state, answer registered
        if (acc && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !mapped || (i_pwrite && busy && (i_paddr == `FCS_REG_CTRL));
            next_st.prdata  = i_pwrite ? 32'h00000000 : rd_mux;
        end
        if (wr_ok && !busy) begin
            case (i_paddr)
                `FCS_REG_ADDR: next_st.addr = i_pwdata[AW-1:0];
                `FCS_REG_DATA: next_st.wdata = i_pwdata[15:0];
                default: ;
            endcase
        end
        if (wr_ok) begin
            case (i_paddr)
                `FCS_REG_CFG:      next_st.wp_req = i_pwdata[0];
                `FCS_REG_IRQ_STAT: irq_clr = i_pwdata[2:0];
                `FCS_REG_IRQ_MASK: next_st.irq_mask = i_pwdata[2:0];
                default: ;
            endcase
        end
        next_st.caddr = st.addr;
        next_st.wr    = 1'b1;
        next_st.req   = !cyc.done;
        case (st.fsm)
            S_IDLE: begin
                next_st.req  = 1'b0;
                // protect pin moves only between sequences
                next_st.wp_n = st.wp_req;
                if (wr_ok && (i_paddr == `FCS_REG_CTRL)) begin
                    next_st.op  = fcs_op_t'(i_pwdata[3:0]);
                    next_st.fsm = S_W1;
                end
            end
            S_W1: begin
                next_st.cdata = plan.code1;
                if (cyc.done) begin
                    case (plan.second)
                        SEC_WRITE: next_st.fsm = S_W2;
                        SEC_READ:  next_st.fsm = S_RD;
                        default:   next_st.fsm = plan.poll ? S_W70 : S_END;
                    endcase
                end
            end
            S_W2: begin
                next_st.cdata = plan.use_data ? st.wdata : plan.code2;
                if (cyc.done) begin
                    next_st.fsm = S_W70;
                end
            end
            S_RD: begin
                next_st.wr = 1'b0;
                if (cyc.done) begin
                    next_st.rdata = cyc.rdata;
                    if (st.op == OP_READ_STATUS) begin
                        next_st.sr = sr_in;
                    end
                    next_st.fsm = S_END;
                end
            end
            S_W70: begin
                next_st.cdata = `FCS_CMD_READ_STATUS;
                if (cyc.done) begin
                    next_st.fsm = S_POLL;
                end
            end
            S_POLL: begin
                // every poll is its own strobed read
                next_st.wr = 1'b0;
                if (cyc.done) begin
                    next_st.sr    = sr_in;
                    next_st.rdata = cyc.rdata;
                    if (sr_in[`FCS_SR_READY]) begin
                        irq_set[`FCS_IRQ_ERR] = sr_in[`FCS_SR_LOCKED]
                                              | sr_in[`FCS_SR_VPP_LOW]
                                              | sr_in[`FCS_SR_PROG_FAIL]
                                              | sr_in[`FCS_SR_ERASE_FAIL];
                        irq_set[`FCS_IRQ_SEQ] = sr_in[`FCS_SR_PROG_FAIL]
                                              & sr_in[`FCS_SR_ERASE_FAIL];
                        next_st.fsm = S_END;
                    end
                end
            end
            S_END: begin
                // extra cycle of steady protect pin
                next_st.req = 1'b0;
                irq_set[`FCS_IRQ_DONE] = 1'b1;
                next_st.fsm = S_IDLE;
            end
            default: begin
                next_st.req = 1'b0;
                next_st.fsm = S_IDLE;
            end
        endcase
        // sticky until software clears; a new event beats the clear
        next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
        next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st      <= '0;
            st.fsm  <= S_IDLE;
            st.wp_n <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign cyc.req     = st.req;
    assign cyc.wr      = st.wr;
    assign cyc.addr    = st.caddr;
    assign cyc.wdata   = st.cdata;
    assign o_prdata    = st.prdata;
    assign o_pready    = st.pready;
    assign o_pslverr   = st.pslverr;
    assign o_flash_wp_n = st.wp_n;
    assign o_irq       = st.irq;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    erase_confirm_a: assert property (
        (st.fsm == S_W2) && (st.op == OP_ERASE) && st.req |-> st.cdata == 16'h00D0)
        else $error("erase confirm code wrong");
    lockdown_code_a: assert property (
        (st.fsm == S_W2) && (st.op == OP_LOCKDOWN) && st.req |-> st.cdata == 16'h002F)
        else $error("lock-down code wrong");
    status_cmd_a: assert property (
        (st.fsm == S_W70) && st.req |-> st.wr && (st.cdata == 16'h0070))
        else $error("status command wrong");
    ident_read_a: assert property (
        (st.fsm == S_W1) && (st.op == OP_READ_ID) && cyc.done
            |=> (st.fsm == S_RD) ##1 (st.req && !st.wr))
        else $error("identifier read not issued");
    program_setup_a: assert property (
        (st.fsm == S_W1) && (st.op == OP_PROGRAM) && st.req |-> st.cdata == 16'h0040)
        else $error("program setup code wrong");
    prot_lock_a: assert property (
        (st.fsm == S_W2) && (st.op == OP_PROT_LOCK) && st.req |-> st.cdata == 16'hFFFD)
        else $error("protection lock data wrong");
    wp_steady_a: assert property (
        (st.fsm != S_IDLE) |=> $stable(o_flash_wp_n))
        else $error("protect pin moved during sequence");
    poll_retry_a: assert property (
        (st.fsm == S_POLL) && cyc.done && !cyc.rdata[7] |=> st.fsm == S_POLL ##1 st.req)
        else $error("busy status not polled again");
    ready_first_a: assert property (
        $rose(st.irq_stat[1]) |-> st.sr[7] && (st.fsm == S_END))
        else $error("error taken while busy");
    rsvd_mask_a: assert property (
        st.sr[0] == 1'b0)
        else $error("reserved status bit not masked");
    seq_error_a: assert property (
        $rose(st.irq_stat[2]) |-> st.sr[7] && st.sr[5] && st.sr[4])
        else $error("sequence error without pattern");
    irq_level_a: assert property (
        |(st.irq_stat & st.irq_mask) |-> o_irq)
        else $error("interrupt not raised");

    program_cov_c: cover property ((st.fsm == S_POLL) && (st.op == OP_PROGRAM) ##1 st.fsm == S_END);
    suspend_cov_c: cover property ((st.op == OP_SUSPEND) && (st.fsm == S_END));
    seq_cov_c:     cover property ($rose(st.irq_stat[2]));
    query_cov_c:   cover property ((st.op == OP_QUERY) && (st.fsm == S_RD) && cyc.done);
endmodule
`default_nettype wire

/* File: fcs_flash_model.sv */
// behavioural flash device on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [19:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_fail,
    output logic      [15:0] o_dq
);
    logic [7:0]  sr    = 8'h80;
    logic [15:0] setup = 16'h0000;
    logic [15:0] mode  = 16'h00FF;
    logic [15:0] last  = 16'h0000;
    int          busy  = 0;
    // released bus shows the inverse, not a held value
    assign o_dq = (!i_ce_n && !i_oe_n) ? last : ~last;
    always @(negedge i_oe_n) begin
        if (busy > 0)
            busy--;
        sr[7] = (busy == 0);
        if (mode == 16'h0090 || mode == 16'h0098)
            last = {mode[7:0], i_addr[7:0]};
        else if (mode == 16'h0070)
            last = {8'h00, sr[7:1], 1'b1};
        else
            last = ~i_addr[15:0];
    end
    always @(posedge i_we_n) if (i_ce_n === 1'b0) begin
        if (setup != 16'h0000) begin
            if (setup == 16'h0020 && i_dq != 16'h00D0
                || setup == 16'h0060 && !(i_dq inside {16'h0001, 16'h00D0, 16'h002F}))
                sr[5:4] = 2'b11;
            else if (setup != 16'h0060) begin
                busy = 2;
                sr[5] = sr[5] | (i_fail && setup == 16'h0020);
                sr[4] = sr[4] | (i_fail && setup != 16'h0020);
            end
            setup = 16'h0000;
            mode  = 16'h0070;
        end else if (i_dq inside {16'h0040, 16'h0010, 16'h0020, 16'h0060, 16'h00C0}) begin
            setup = i_dq;
            mode  = 16'h0070;
        end else if (i_dq == 16'h0050)
            sr[5:1] = 5'h00;
        else
            mode = (i_dq inside {16'h00B0, 16'h00D0}) ? 16'h0070 : i_dq;
    end
endmodule
`default_nettype wire

/* File: flash_command_status_unit_bench.sv */
// self-checking bench of the flash command controller
`timescale 1ns/1ps
`default_nettype none
module flash_command_status_unit_bench;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, fail = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, ce_n, oe_n, we_n, dq_oe, wp_n, irq;
    logic [19:0] fa;
    logic [15:0] cdq, mdq;
    int          num_errors = 0, checked = 0;
    wire  logic [15:0] dq = dq_oe ? mdq : cdq;
    fcs_flash_ctrl dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_flash_ce_n(ce_n),
        .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_addr(fa), .o_flash_dq(cdq),
        .o_flash_dq_oe(dq_oe), .i_flash_dq(dq), .o_flash_wp_n(wp_n), .o_irq(irq));
    fcs_flash_model flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(fa),
        .i_dq(dq), .i_fail(fail), .o_dq(mdq));
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // values read here are those sampled by this edge
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic go(input logic [3:0] op);
        apb(1'b1, 8'h00, {28'h0, op});
        do apb(1'b0, 8'h10, 32'h0); while (r[0] !== 1'b0);
    endtask
    task automatic run(input logic [3:0] op, input logic f, input logic [7:0] exp);
        fail <= f;
        go(op);
        chk(r[15:8], exp);
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 8'h20, 32'h0);
        chk(e, 32'h1);
        apb(1'b1, 8'h04, 32'h12);
        apb(1'b1, 8'h08, 32'h1234);
        apb(1'b1, 8'h1C, 32'h7);
        run(4'h5, 1'b0, 8'h80);
        chk(irq, 32'h1);
        apb(1'b1, 8'h18, 32'h7);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        run(4'h5, 1'b1, 8'h90);
        run(4'h6, 1'b0, 8'h90);
        go(4'h4);
        run(4'h7, 1'b1, 8'hA0);
        go(4'h4);
        for (int k = 10; k < 15; k++)
            run(k[3:0], 1'b0, 8'h80);
        run(4'h8, 1'b0, 8'h80);
        go(4'h9);
        run(4'h3, 1'b0, 8'h80);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h81);
        go(4'h0);
        go(4'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h9012);
        go(4'h2);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h9812);
        apb(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge clk);
        chk(wp_n, 32'h1);
        give_verdict();
    end
    // run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
